// file: inc/bwt_map.svh
// Register map, field positions, reset values and timing figures of the basic/watchdog timer.
// Assumes a plain register port with byte addresses as printed.
`ifndef BWT_MAP_SVH
`define BWT_MAP_SVH

// ==========================================================================
// Register offsets
`define BWT_ADDR_CONTROL 16'ha002
`define BWT_ADDR_COUNT 16'ha007
`define BWT_ADDR_IRQ_STATUS 16'ha010
`define BWT_ADDR_IRQ_MASK 16'ha014
`define BWT_ADDR_SYS_CONTROL 16'ha018
`define BWT_ADDR_STATUS 16'ha01c

// ==========================================================================
// Control fields
`define BWT_CTL_WDOG_CLR 0
`define BWT_CTL_BASIC_CLR 1
`define BWT_CTL_SEL_HI 3
`define BWT_CTL_SEL_LO 2
`define BWT_CTL_KEY_HI 15
`define BWT_CTL_KEY_LO 8
`define BWT_CTL_RESET 16'h0000
`define BWT_CTL_KEEP_MASK 16'hff0c
`define BWT_WDOG_KEY 8'ha5
`define BWT_SYS_GATE_BIT 6
`define BWT_SYS_RESET 8'h00

// ==========================================================================
// Interrupt status bits
`define BWT_IRQ_BASIC_OVF 0
`define BWT_IRQ_WDOG_OVF 1
`define BWT_IRQ_RESET 2'h0

// ==========================================================================
// Prescaler taps and counter figures
`define BWT_DIV_TAP_9 8
`define BWT_DIV_TAP_11 10
`define BWT_DIV_TAP_12 11
`define BWT_DIV_TAP_13 12
`define BWT_PRE_RESET 13'h0000
`define BWT_BASIC_MAX 8'hff
`define BWT_BASIC_RESET 8'h00
`define BWT_WDOG_MAX 3'h7
`define BWT_WDOG_RESET 3'h0
`define BWT_START_BIT 4
`define BWT_SYSRST_LEN 4'hf

`endif

// file: inc/bwt_pkg.sv
// Types shared by the basic/watchdog timer design.
// Assumes nothing beyond a SystemVerilog compiler.
package bwt_pkg;
    // Count clock selection, encoded as control bits [3:2]
    typedef enum logic [1:0] {
        BWT_DIV_8192 = 2'h0,
        BWT_DIV_4096 = 2'h1,
        BWT_DIV_2048 = 2'h2,
        BWT_DIV_512 = 2'h3
    } bwt_sel_t;

    // Start-delay sequencer state
    typedef enum logic [1:0] {
        BWT_ST_HOLD,
        BWT_ST_RUN,
        BWT_ST_RESET
    } bwt_state_t;
endpackage : bwt_pkg

// file: src/bwt_prescaler.sv
// Prescaler of the external clock producing one-cycle count ticks.
// Assumes ref_clk is the external clock input and reset is already synchronised.
`timescale 1ns/100ps
`include "bwt_map.svh"
module bwt_prescaler
    import bwt_pkg::*;
(
    input wire logic ref_clk, // External clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic [1:0] sel, // Division select
    output logic tick // One-cycle count tick
);
    // ======================================================================
    // Free running divider
    logic [12:0] pre;
    logic [12:0] next_pre;
    logic next_tick;

    // Tap index for the selected division
    function automatic int unsigned tap_of(input logic [1:0] s);
        case (bwt_sel_t'(s))
            BWT_DIV_512: tap_of = `BWT_DIV_TAP_9;
            BWT_DIV_2048: tap_of = `BWT_DIV_TAP_11;
            BWT_DIV_4096: tap_of = `BWT_DIV_TAP_12;
            default: tap_of = `BWT_DIV_TAP_13;
        endcase
    endfunction : tap_of

    // Tick when all bits below and at the tap are one
    always_comb begin
        next_pre = pre + 13'h0001;
        next_tick = 1'b1;
        for (int i = 0; i <= `BWT_DIV_TAP_13; i++) begin
            if (i <= tap_of(sel) && !pre[i]) begin
                next_tick = 1'b0;
            end
        end
    end

    // Register divider and tick
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= `BWT_PRE_RESET;
            tick <= 1'b0;
        end else begin
            pre <= next_pre;
            tick <= next_tick;
        end
    end
endmodule : bwt_prescaler

// file: src/bwt_timer.sv
// Basic interval timer with 3-bit watchdog, start delay and interrupt logic.
// Assumes a register master that keeps strobes one cycle long and never both at once.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "bwt_map.svh"

module bwt_timer
    import bwt_pkg::*;
(
    input wire logic ref_clk, // External clock, 250 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [15:0] addr, // Register byte address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic stop_release, // Pulse when stop mode ends
    output logic [15:0] rdata, // Read data, cycle after rd
    output logic irq, // Level interrupt
    output logic cpu_start, // CPU may start
    output logic sys_reset // Watchdog system reset request
);
    // ======================================================================
    // Reset synchroniser
    logic rst_meta;
    logic rst_n;

    // Two-stage release of the reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ======================================================================
    // State
    logic [15:0] ctl;
    logic [7:0] sysctl;
    logic [7:0] basic;
    logic [2:0] wdog;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    bwt_state_t state;
    logic [3:0] rst_cnt;
    logic tick;

    logic [15:0] next_ctl;
    logic [7:0] next_sysctl;
    logic [7:0] next_basic;
    logic [2:0] next_wdog;
    logic [1:0] next_irq_stat;
    logic [1:0] next_irq_mask;
    bwt_state_t next_state;
    logic [3:0] next_rst_cnt;
    logic [15:0] next_rdata;
    logic next_irq;
    logic next_cpu_start;
    logic next_sys_reset;
    logic basic_ovf;
    logic wdog_ovf;
    logic wdog_run;
    logic wr_ctl;

    // Count clock from the prescaler
    bwt_prescaler u_pre (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sel(ctl[`BWT_CTL_SEL_HI:`BWT_CTL_SEL_LO]),
        .tick(tick)
    );

    // Address match helper
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // ======================================================================
    // Counters and control
    always_comb begin
        wr_ctl = wr && hit(addr, `BWT_ADDR_CONTROL);
        wdog_run = (ctl[`BWT_CTL_KEY_HI:`BWT_CTL_KEY_LO] != `BWT_WDOG_KEY);
        basic_ovf = tick && !sysctl[`BWT_SYS_GATE_BIT] && (basic == `BWT_BASIC_MAX);
        wdog_ovf = basic_ovf && wdog_run && (wdog == `BWT_WDOG_MAX);
        next_ctl = ctl;
        next_sysctl = sysctl;
        // Clear bits are never stored, so they read back as zero
        if (wr_ctl) begin
            next_ctl = wdata & `BWT_CTL_KEEP_MASK;
        end
        if (wr && hit(addr, `BWT_ADDR_SYS_CONTROL)) begin
            next_sysctl = wdata[7:0];
        end
        // Basic counter: gated, clear wins
        next_basic = basic;
        if (wr_ctl && wdata[`BWT_CTL_BASIC_CLR]) begin
            next_basic = `BWT_BASIC_RESET;
        end else if (tick && !sysctl[`BWT_SYS_GATE_BIT]) begin
            next_basic = basic + 8'h01;
        end
        // Watchdog counter: runs on basic overflow unless keyed off
        next_wdog = wdog;
        if (wr_ctl && wdata[`BWT_CTL_WDOG_CLR]) begin
            next_wdog = `BWT_WDOG_RESET;
        end else if (basic_ovf && wdog_run) begin
            next_wdog = wdog + 3'h1;
        end
    end

    // ======================================================================
    // Interrupt status and mask; set beats clear
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr && hit(addr, `BWT_ADDR_IRQ_MASK)) begin
            next_irq_mask = wdata[1:0];
        end
        if (wr && hit(addr, `BWT_ADDR_IRQ_STATUS)) begin
            next_irq_stat = irq_stat & ~wdata[1:0];
        end
        if (basic_ovf) begin
            next_irq_stat[`BWT_IRQ_BASIC_OVF] = 1'b1;
        end
        if (wdog_ovf) begin
            next_irq_stat[`BWT_IRQ_WDOG_OVF] = 1'b1;
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ======================================================================
    // Start delay and system reset sequencer
    always_comb begin
        next_state = state;
        next_rst_cnt = rst_cnt;
        next_cpu_start = cpu_start;
        next_sys_reset = 1'b0;
        case (state)
            BWT_ST_HOLD: begin
                next_cpu_start = 1'b0;
                // A watchdog overflow still resets while the start delay runs
                if (wdog_ovf) begin
                    next_state = BWT_ST_RESET;
                    next_rst_cnt = `BWT_SYSRST_LEN;
                    next_sys_reset = 1'b1;
                end else if (basic[`BWT_START_BIT]) begin
                    next_state = BWT_ST_RUN;
                    next_cpu_start = 1'b1;
                end
            end
            BWT_ST_RUN: begin
                next_cpu_start = 1'b1;
                if (wdog_ovf) begin
                    next_state = BWT_ST_RESET;
                    next_rst_cnt = `BWT_SYSRST_LEN;
                    next_cpu_start = 1'b0;
                    next_sys_reset = 1'b1;
                end else if (stop_release) begin
                    next_state = BWT_ST_HOLD;
                    next_cpu_start = 1'b0;
                end
            end
            default: begin
                next_cpu_start = 1'b0;
                next_sys_reset = 1'b1;
                next_rst_cnt = rst_cnt - 4'h1;
                if (rst_cnt == 4'h0) begin
                    next_state = BWT_ST_HOLD;
                    next_sys_reset = 1'b0;
                end
            end
        endcase
    end

    // ======================================================================
    // Read mux
    always_comb begin
        next_rdata = 16'h0000;
        if (!rd) begin
            next_rdata = 16'h0000;
        end else if (hit(addr, `BWT_ADDR_CONTROL)) begin
            next_rdata = ctl;
        end else if (hit(addr, `BWT_ADDR_COUNT)) begin
            next_rdata = {8'h00, basic};
        end else if (hit(addr, `BWT_ADDR_IRQ_STATUS)) begin
            next_rdata = {14'h0000, irq_stat};
        end else if (hit(addr, `BWT_ADDR_IRQ_MASK)) begin
            next_rdata = {14'h0000, irq_mask};
        end else if (hit(addr, `BWT_ADDR_SYS_CONTROL)) begin
            next_rdata = {8'h00, sysctl};
        end else if (hit(addr, `BWT_ADDR_STATUS)) begin
            next_rdata = {11'h000, wdog, state == BWT_ST_RUN, wdog_run};
        end
    end

    // ======================================================================
    // Register all state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= `BWT_CTL_RESET;
            sysctl <= `BWT_SYS_RESET;
            basic <= `BWT_BASIC_RESET;
            wdog <= `BWT_WDOG_RESET;
            irq_stat <= `BWT_IRQ_RESET;
            irq_mask <= `BWT_IRQ_RESET;
            state <= BWT_ST_HOLD;
            rst_cnt <= 4'h0;
            rdata <= 16'h0000;
            irq <= 1'b0;
            cpu_start <= 1'b0;
            sys_reset <= 1'b0;
        end else begin
            ctl <= next_ctl;
            sysctl <= next_sysctl;
            basic <= next_basic;
            wdog <= next_wdog;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            state <= next_state;
            rst_cnt <= next_rst_cnt;
            rdata <= next_rdata;
            irq <= next_irq;
            cpu_start <= next_cpu_start;
            sys_reset <= next_sys_reset;
        end
    end

    // ======================================================================
    // Checks
    sequence s_wdog_clr;
        wr_ctl && wdata[`BWT_CTL_WDOG_CLR];
    endsequence

    a_basic_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        basic_ovf |=> basic == 8'h00 && irq_stat[0]) else $error("basic wrap failed");
    a_basic_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sysctl[6] && !wr_ctl |=> $stable(basic)) else $error("gated counter moved");
    a_basic_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick && !sysctl[6] && !wr_ctl |=> basic == $past(basic) + 8'h01) else $error("count step wrong");
    a_basic_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_ctl && wdata[1] |=> basic == 8'h00) else $error("basic clear lost");
    a_wdog_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_wdog_clr |=> wdog == 3'h0 && ctl[0] == 1'b0) else $error("watchdog clear lost");
    a_wdog_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        basic_ovf && wdog_run && !(wr_ctl && wdata[`BWT_CTL_WDOG_CLR]) |=> wdog == $past(wdog) + 3'h1)
        else $error("watchdog step wrong");
    a_wdog_keyed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctl[`BWT_CTL_KEY_HI:`BWT_CTL_KEY_LO] == `BWT_WDOG_KEY && !wr_ctl |=> $stable(wdog))
        else $error("keyed watchdog moved");
    a_sys_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdog_ovf |=> sys_reset [*8]) else $error("system reset missing");
    a_start_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == BWT_ST_HOLD && !basic[4] |=> !cpu_start) else $error("cpu start too early");
    a_prescale: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctl[3:2] == 2'h3 && tick && !$changed(ctl[3:2]) |=> !tick [*8]) else $error("tick spacing wrong");
endmodule : bwt_timer

// file: testbench/tb.sv
// Self-checking bench for the basic/watchdog timer: register tasks and directed sequences.
// Assumes bwt_timer with its map header on the include path; run is long because counts are not shortened.
`timescale 1ns/100ps
`include "bwt_map.svh"
module tb
    import bwt_pkg::*;
();
    // ==========================================================================
    // Stimulus and observed signals
    logic ref_clk;
    logic rstn;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic stop_release;
    logic [15:0] rdata;
    logic irq;
    logic cpu_start;
    logic sys_reset;
    int bad_count;
    int cmp_count;
    int cyc;
    logic [15:0] v0;
    logic [15:0] v1;
    int t0;
    int t1;
    bwt_sel_t sel_tab [4];
    int div_tab [4];

    bwt_timer DUT (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .stop_release(stop_release),
        .rdata(rdata),
        .irq(irq),
        .cpu_start(cpu_start),
        .sys_reset(sys_reset)
    );

    // Clock at 250 MHz and a free cycle count for interval checks
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
    end

    // ==========================================================================
    // Helper tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Read a register and compare it in one call
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask : rd_chk

    // Wait for cpu_start (which 0) or irq (which 1) to go high, bounded
    task automatic wait_hi(input int which, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge ref_clk);
            #1;
            if ((which == 0 ? cpu_start : irq) === 1'b1) break;
        end
        if (i >= lim) begin
            bad_count++;
            conclude();
        end
    endtask : wait_hi

    // Reads the count every cycle until it changes; returns the cycle and new value
    task automatic next_tick(input int lim, output int at, output logic [15:0] val);
        logic [15:0] prev;
        int i;
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= `BWT_ADDR_COUNT;
        @(posedge ref_clk);
        #1 prev = rdata;
        for (i = 0; i < lim; i++) begin
            @(posedge ref_clk);
            #1;
            if (rdata !== prev) break;
        end
        at = cyc;
        val = rdata;
        @(posedge ref_clk);
        rd <= 1'b0;
        if (i >= lim) begin
            bad_count++;
            conclude();
        end
    endtask : next_tick

    // ==========================================================================
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        stop_release = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        cyc = 0;
        sel_tab = '{BWT_DIV_8192, BWT_DIV_4096, BWT_DIV_2048, BWT_DIV_512};
        div_tab = '{8192, 4096, 2048, 512};
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk({13'h0000, irq, cpu_start, sys_reset}, 16'h0000);
        rd_chk(`BWT_ADDR_CONTROL, 16'h0000);
        rd_chk(`BWT_ADDR_STATUS, 16'h0001);
        rd_chk(`BWT_ADDR_COUNT, 16'h0000);
        // Count is read-only, unmapped space reads zero
        wr_reg(`BWT_ADDR_COUNT, 16'h00ff);
        rd_chk(`BWT_ADDR_COUNT, 16'h0000);
        rd_chk(16'ha004, 16'h0000);
        // Fastest select, then start delay ends when count bit 4 sets
        wr_reg(`BWT_ADDR_CONTROL, 16'h000c);
        rd_chk(`BWT_ADDR_CONTROL, 16'h000c);
        wait_hi(0, 10000);
        rd_chk(`BWT_ADDR_COUNT, 16'h0010);
        rd_chk(`BWT_ADDR_STATUS, 16'h0003);
        // Tick spacing for every select code, count steps by one
        for (int k = 0; k < 4; k++) begin
            wr_reg(`BWT_ADDR_CONTROL, {12'h000, sel_tab[k], 2'b00});
            next_tick(10000, t0, v0);
            next_tick(10000, t1, v1);
            chk(v1, v0 + 16'h0001);
            chk(16'(t1 - t0), 16'(div_tab[k]));
        end
        // Power gate freezes the count
        wr_reg(`BWT_ADDR_SYS_CONTROL, 16'h0040);
        rd_chk(`BWT_ADDR_SYS_CONTROL, 16'h0040);
        rd_reg(`BWT_ADDR_COUNT, v0);
        repeat (1100) @(posedge ref_clk);
        rd_chk(`BWT_ADDR_COUNT, v0);
        wr_reg(`BWT_ADDR_SYS_CONTROL, 16'h0000);
        // Basic clear self-clears; stop release re-arms the start delay
        wr_reg(`BWT_ADDR_CONTROL, 16'h000e);
        rd_chk(`BWT_ADDR_CONTROL, 16'h000c);
        rd_chk(`BWT_ADDR_COUNT, 16'h0000);
        @(posedge ref_clk);
        stop_release <= 1'b1;
        @(posedge ref_clk);
        stop_release <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk({15'h0000, cpu_start}, 16'h0000);
        wait_hi(0, 10000);
        rd_chk(`BWT_ADDR_COUNT, 16'h0010);
        // Overflow raises the interrupt and steps the watchdog
        wr_reg(`BWT_ADDR_IRQ_MASK, 16'h0001);
        wait_hi(1, 140000);
        rd_chk(`BWT_ADDR_COUNT, 16'h0000);
        rd_chk(`BWT_ADDR_IRQ_STATUS, 16'h0001);
        rd_chk(`BWT_ADDR_STATUS, 16'h0007);
        chk({15'h0000, sys_reset}, 16'h0000);
        // Mask, unmask, then write-one-to-clear
        wr_reg(`BWT_ADDR_IRQ_MASK, 16'h0000);
        rd_chk(`BWT_ADDR_IRQ_MASK, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(`BWT_ADDR_IRQ_MASK, 16'h0001);
        rd_chk(`BWT_ADDR_IRQ_MASK, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(`BWT_ADDR_IRQ_STATUS, 16'h0001);
        rd_chk(`BWT_ADDR_IRQ_STATUS, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // Software service clears the watchdog count
        wr_reg(`BWT_ADDR_CONTROL, 16'h000d);
        rd_chk(`BWT_ADDR_STATUS, 16'h0003);
        rd_chk(`BWT_ADDR_CONTROL, 16'h000c);
        // Disable key stops the watchdog
        wr_reg(`BWT_ADDR_CONTROL, 16'ha50c);
        rd_chk(`BWT_ADDR_CONTROL, 16'ha50c);
        rd_chk(`BWT_ADDR_STATUS, 16'h0002);
        conclude();
    end
endmodule : tb
